// File: pkg/gpio_pkg.sv
// constants, register map and carrier types of the three-port gpio block
// assumes one 50 mhz clock and an axi4-lite master on the same clock
// Behaviour
// - each first-port pin has a pullup enable bit; on a non-keyboard pin set connects, clear drops it
// - a first-port pullup applies only while the pin's direction is input
// - keyboard pins take pullup or pulldown from the keyboard polarity setting
// - eight second-port pins share converter inputs and never have pullups
// - second-port data latch is read/write and untouched by reset
// - a converter-selected second-port pin is forced to analog input
// - second-port direction bit 1 enables the output buffer, 0 makes input
// - reset clears second-port direction, all pins start as inputs
// - second-port data read gives latch for outputs, pin level for inputs
// - data writes with wstrb bit 0 set load the latch and never change input readback
// - third port has seven pins whose data latch survives reset
// - third-port pins 1 and 0 carry can receive and transmit when enabled
// - reset clears third-port direction; 1 selects output, 0 input
// - third-port data read gives latch for outputs, pin level for inputs
// - third-port pullup bit pulls an input pin up; outputs ignore it
// - first-port direction resets to inputs; 1 output, 0 input
package gpio_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PA_W = 8;
	localparam int unsigned PB_W = 8;
	localparam int unsigned PC_W = 7;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_PB_DATA = 6'h01;
	localparam logic [5:0] IDX_PC_DATA = 6'h02;
	localparam logic [5:0] IDX_PA_DIR = 6'h04;
	localparam logic [5:0] IDX_PB_DIR = 6'h05;
	localparam logic [5:0] IDX_PC_DIR = 6'h06;
	localparam logic [5:0] IDX_PA_PUE = 6'h0c;
	localparam logic [5:0] IDX_PC_PUE = 6'h0e;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int unsigned CAN_TX_BIT = 0;
	localparam int unsigned CAN_RX_BIT = 1;

	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_PB_DATA = 3'b001,
		SEL_PC_DATA = 3'b010,
		SEL_PA_DIR = 3'b011,
		SEL_PB_DIR = 3'b100,
		SEL_PC_DIR = 3'b101,
		SEL_PA_PUE = 3'b110,
		SEL_PC_PUE = 3'b111
	} gpio_sel_t;

	typedef struct packed {
		logic [PB_W-1:0] o;
		logic [PB_W-1:0] oe;
	} gpio_pin8_t;

	typedef struct packed {
		logic [PC_W-1:0] o;
		logic [PC_W-1:0] oe;
		logic [PC_W-1:0] pu;
	} gpio_pin7_t;

	typedef struct packed {
		logic [PA_W-1:0] up;
		logic [PA_W-1:0] dn;
	} gpio_pull8_t;

	// address to register select, low two bits ignored
	function automatic gpio_sel_t gpio_decode(input logic [ADDR_W-1:0] a);
		gpio_sel_t s;
		s = SEL_NONE;
		unique case (a[ADDR_W-1:2])
			IDX_PB_DATA: s = SEL_PB_DATA;
			IDX_PC_DATA: s = SEL_PC_DATA;
			IDX_PA_DIR: s = SEL_PA_DIR;
			IDX_PB_DIR: s = SEL_PB_DIR;
			IDX_PC_DIR: s = SEL_PC_DIR;
			IDX_PA_PUE: s = SEL_PA_PUE;
			IDX_PC_PUE: s = SEL_PC_PUE;
			default: s = SEL_NONE;
		endcase
		return s;
	endfunction : gpio_decode

endpackage : gpio_pkg

// File: rtl/gpio_ports.sv
// gpio ports a, b and c behind an axi4-lite register slave
// assumes pins arrive asynchronous; kbd, converter and can signals on aclk
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module gpio_ports import gpio_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	// first port pulls and keyboard control
	input wire logic [PA_W-1:0] keyboard_inputs,
	input wire logic [PA_W-1:0] keyboard_polarity_control,
	output gpio_pull8_t pa_pull,
	// second port pins and converter select
	input wire logic [PB_W-1:0] pb_pin_i,
	input wire logic [PB_W-1:0] converter_input_channels,
	output gpio_pin8_t pb_pin,
	// third port pins and can controller
	input wire logic [PC_W-1:0] pc_pin_i,
	input wire logic can_controller_enable,
	input wire logic can_tx,
	output logic can_rx,
	output gpio_pin7_t pc_pin
);

	// configuration and latches
	logic [PA_W-1:0] first_port_direction_q;
	logic [PA_W-1:0] first_port_pullup_enable_q;
	logic [PB_W-1:0] second_port_direction_q;
	logic [PB_W-1:0] second_port_data_q;
	logic [PC_W-1:0] third_port_direction_q;
	logic [PC_W-1:0] third_port_data_q;
	logic [PC_W-1:0] third_port_pullup_enable_q;
	logic second_port_loaded_q;
	logic third_port_loaded_q;

	// pin synchronisers
	logic [PB_W-1:0] pb_meta_q;
	logic [PB_W-1:0] pb_sync_q;
	logic [PC_W-1:0] pc_meta_q;
	logic [PC_W-1:0] pc_sync_q;

	// bus state
	logic wr_fire;
	logic ar_fire;
	gpio_sel_t wr_sel;
	gpio_sel_t rd_sel;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0] rresp_q;
	logic [DATA_W-1:0] rd_word;

	// pin drive state
	gpio_pull8_t pa_pull_d;
	gpio_pull8_t pa_pull_q;
	gpio_pin8_t pb_pin_d;
	gpio_pin8_t pb_pin_q;
	gpio_pin7_t pc_pin_d;
	gpio_pin7_t pc_pin_q;
	logic can_rx_q;

	// write takes address and data together
	assign wr_fire = awvalid && wvalid && !bvalid_q;
	assign awready = wr_fire;
	assign wready = wr_fire;
	assign wr_sel = gpio_decode(awaddr);

	assign ar_fire = arvalid && !rvalid_q;
	assign arready = !rvalid_q;
	assign rd_sel = gpio_decode(araddr);

	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// direction and pullup registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_port_direction_q <= '0;
			second_port_direction_q <= '0;
			third_port_direction_q <= '0;
			first_port_pullup_enable_q <= '0;
			third_port_pullup_enable_q <= '0;
		end else if (wr_fire && wstrb[0]) begin
			unique case (wr_sel)
				SEL_PA_DIR: first_port_direction_q <= wdata[PA_W-1:0];
				SEL_PB_DIR: second_port_direction_q <= wdata[PB_W-1:0];
				SEL_PC_DIR: third_port_direction_q <= wdata[PC_W-1:0];
				SEL_PA_PUE: first_port_pullup_enable_q <= wdata[PA_W-1:0];
				SEL_PC_PUE: third_port_pullup_enable_q <= wdata[PC_W-1:0];
				SEL_NONE, SEL_PB_DATA, SEL_PC_DATA: begin
				end
			endcase
		end
	end

	// data latches keep their contents across reset
	always_ff @(posedge aclk) begin
		if (wr_fire && wstrb[0]) begin
			if (wr_sel == SEL_PB_DATA) begin
				second_port_data_q <= wdata[PB_W-1:0];
				second_port_loaded_q <= 1'b1;
			end
			if (wr_sel == SEL_PC_DATA) begin
				third_port_data_q <= wdata[PC_W-1:0];
				third_port_loaded_q <= 1'b1;
			end
		end
	end

	// two-stage pin synchronisers
	always_ff @(posedge aclk) begin
		pb_meta_q <= pb_pin_i;
		pb_sync_q <= pb_meta_q;
		pc_meta_q <= pc_pin_i;
		pc_sync_q <= pc_meta_q;
	end

	// read mux, latch for outputs and pin for inputs
	always_comb begin
		rd_word = '0;
		unique case (rd_sel)
			SEL_PB_DATA: rd_word[PB_W-1:0] =
				(second_port_direction_q & second_port_data_q) |
				(~second_port_direction_q & pb_sync_q);
			SEL_PC_DATA: rd_word[PC_W-1:0] =
				(third_port_direction_q & third_port_data_q) |
				(~third_port_direction_q & pc_sync_q);
			SEL_PA_DIR: rd_word[PA_W-1:0] = first_port_direction_q;
			SEL_PB_DIR: rd_word[PB_W-1:0] = second_port_direction_q;
			SEL_PC_DIR: rd_word[PC_W-1:0] = third_port_direction_q;
			SEL_PA_PUE: rd_word[PA_W-1:0] = first_port_pullup_enable_q;
			SEL_PC_PUE: rd_word[PC_W-1:0] = third_port_pullup_enable_q;
			SEL_NONE: rd_word = '0;
		endcase
	end

	// read response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// first port pulls, per pin
	generate
		for (genvar i = 0; i < PA_W; i++) begin : g_pa_pull
			always_comb begin
				pa_pull_d.up[i] = 1'b0;
				pa_pull_d.dn[i] = 1'b0;
				if (!first_port_direction_q[i]) begin
					if (keyboard_inputs[i]) begin
						pa_pull_d.up[i] = !keyboard_polarity_control[i];
						pa_pull_d.dn[i] = keyboard_polarity_control[i];
					end else begin
						pa_pull_d.up[i] = first_port_pullup_enable_q[i];
					end
				end
			end
		end
	endgenerate

	// second port drive, converter select wins
	always_comb begin
		pb_pin_d.o = second_port_data_q;
		pb_pin_d.oe = second_port_direction_q &
			~converter_input_channels;
	end

	// third port drive with can takeover
	always_comb begin
		pc_pin_d.o = third_port_data_q;
		pc_pin_d.oe = third_port_direction_q;
		if (can_controller_enable) begin
			pc_pin_d.o[CAN_TX_BIT] = can_tx;
			pc_pin_d.oe[CAN_TX_BIT] = 1'b1;
			pc_pin_d.oe[CAN_RX_BIT] = 1'b0;
		end
		pc_pin_d.pu = third_port_pullup_enable_q & ~pc_pin_d.oe;
	end

	// registered pin outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pa_pull_q <= '0;
			pb_pin_q <= '0;
			pc_pin_q <= '0;
			can_rx_q <= 1'b1;
		end else begin
			pa_pull_q <= pa_pull_d;
			pb_pin_q <= pb_pin_d;
			pc_pin_q <= pc_pin_d;
			can_rx_q <= can_controller_enable ?
				pc_sync_q[CAN_RX_BIT] : 1'b1;
		end
	end

	assign pa_pull = pa_pull_q;
	assign pb_pin = pb_pin_q;
	assign pc_pin = pc_pin_q;
	assign can_rx = can_rx_q;

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence wr_to(logic [5:0] idx);
		wr_fire && wstrb[0] && awaddr[ADDR_W-1:2] == idx;
	endsequence

	sequence rd_of(logic [5:0] idx);
		ar_fire && araddr[ADDR_W-1:2] == idx;
	endsequence

	pa_pullup_gate_a: assert property (
		##1 (pa_pull.up & $past(first_port_direction_q)) == '0)
		else $error("first port pullup on an output pin");

	pa_pullup_on_a: assert property (
		aresetn |=> pa_pull.up == (($past(first_port_pullup_enable_q) &
			~$past(first_port_direction_q) & ~$past(keyboard_inputs)) |
			($past(keyboard_inputs) & ~$past(first_port_direction_q) &
			~$past(keyboard_polarity_control))))
		else $error("first port pullup does not follow enable");

	kbd_pulldown_a: assert property (
		aresetn |=> pa_pull.dn == ($past(keyboard_inputs) &
			$past(keyboard_polarity_control) &
			~$past(first_port_direction_q)))
		else $error("keyboard pulldown wrong");

	pb_analog_oe_a: assert property (
		##1 (pb_pin.oe & $past(converter_input_channels)) == '0)
		else $error("converter pin still driven");

	pb_dir_oe_a: assert property (
		(converter_input_channels == '0) |=>
			pb_pin.oe == $past(second_port_direction_q))
		else $error("second port buffer not from direction");

	dir_reset_a: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> second_port_direction_q == '0 &&
			third_port_direction_q == '0 && first_port_direction_q == '0)
		else $error("direction not cleared by reset");

	latch_keep_a: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn && third_port_loaded_q |=>
			third_port_data_q == $past(third_port_data_q))
		else $error("third port latch changed in reset");

	pb_latch_keep_a: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn && second_port_loaded_q |=>
			second_port_data_q == $past(second_port_data_q))
		else $error("second port latch changed in reset");

	pb_read_mux_a: assert property (
		rd_of(IDX_PB_DATA) |=> rvalid && rdata[PB_W-1:0] ==
			(($past(second_port_direction_q) & $past(second_port_data_q)) |
			(~$past(second_port_direction_q) & $past(pb_sync_q))))
		else $error("second port read mux wrong");

	pc_read_mux_a: assert property (
		rd_of(IDX_PC_DATA) |=> rvalid && rdata[DATA_W-1:PC_W] == '0 &&
			rdata[PC_W-1:0] ==
			(($past(third_port_direction_q) & $past(third_port_data_q)) |
			(~$past(third_port_direction_q) & $past(pc_sync_q))))
		else $error("third port read mux wrong");

	pb_latch_write_a: assert property (
		wr_to(IDX_PB_DATA) |=> second_port_data_q == $past(wdata[PB_W-1:0])
			&& bvalid)
		else $error("second port latch not written");

	pc_latch_write_a: assert property (
		wr_to(IDX_PC_DATA) |=> third_port_data_q == $past(wdata[PC_W-1:0]))
		else $error("third port latch not written");

	pb_drive_val_a: assert property (
		aresetn && second_port_loaded_q |=>
			pb_pin.o == $past(second_port_data_q))
		else $error("second port drive value not from latch");

	pc_dir_oe_a: assert property (
		aresetn && !can_controller_enable |=>
			pc_pin.oe == $past(third_port_direction_q))
		else $error("third port buffer not from direction");

	can_rx_idle_a: assert property (
		aresetn && !can_controller_enable |=> can_rx)
		else $error("can receive not idle while disabled");

	can_pins_a: assert property (
		aresetn && can_controller_enable |=> pc_pin.oe[CAN_TX_BIT] &&
			!pc_pin.oe[CAN_RX_BIT] && pc_pin.o[CAN_TX_BIT] == $past(can_tx))
		else $error("can pins not taken over");

	pc_pullup_a: assert property (
		##1 pc_pin.pu == ($past(third_port_pullup_enable_q) & ~pc_pin.oe))
		else $error("third port pullup wrong");

	pc_bit7_a: assert property (
		ar_fire && (araddr[ADDR_W-1:2] == IDX_PC_DIR ||
			araddr[ADDR_W-1:2] == IDX_PC_PUE) |=> rdata[DATA_W-1:PC_W] == '0)
		else $error("third port upper bits not zero");

endmodule : gpio_ports

// File: bench/gpio_pin_model.sv
// far-side pad model: resolves pad levels of the second and third ports
// assumes the design's drive, enable and pullup outputs change on aclk
`timescale 1ns/1ps
module gpio_pin_model import gpio_pkg::*; (
	// clock
	input wire logic aclk,
	// design pad controls
	input wire gpio_pin8_t pb_pin,
	input wire gpio_pin7_t pc_pin,
	// external drivers
	input wire logic [PB_W-1:0] ext_b,
	input wire logic [PC_W-1:0] ext_c,
	input wire logic [PC_W-1:0] ext_c_en,
	// pad levels
	output logic [PB_W-1:0] pb_lvl,
	output logic [PC_W-1:0] pc_lvl
);
	logic float_q = 1'b0;

	// undriven pad with no pull wanders every cycle
	always_ff @(posedge aclk) begin
		float_q <= ~float_q;
	end

	// no pullups on port b: the far side always holds an input pad
	assign pb_lvl = (pb_pin.oe & pb_pin.o) | (~pb_pin.oe & ext_b);

	always_comb begin
		for (int i = 0; i < PC_W; i++) begin
			if (pc_pin.oe[i]) pc_lvl[i] = pc_pin.o[i];
			else if (ext_c_en[i]) pc_lvl[i] = ext_c[i];
			else if (pc_pin.pu[i]) pc_lvl[i] = 1'b1;
			else pc_lvl[i] = float_q;
		end
	end
endmodule : gpio_pin_model

// File: bench/gpio_ports_a_b_c_tb_top.sv
// testbench of the three-port gpio block over axi4-lite
// assumes the pad model in gpio_pin_model and a 50 mhz clock
`timescale 1ns/1ps
module gpio_ports_a_b_c_tb_top import gpio_pkg::*;;
	localparam logic [7:0] A_PBD = {IDX_PB_DATA, 2'b00};
	localparam logic [7:0] A_PCD = {IDX_PC_DATA, 2'b00};
	localparam logic [7:0] A_PAR = {IDX_PA_DIR, 2'b00};
	localparam logic [7:0] A_PBR = {IDX_PB_DIR, 2'b00};
	localparam logic [7:0] A_PCR = {IDX_PC_DIR, 2'b00};
	localparam logic [7:0] A_PAU = {IDX_PA_PUE, 2'b00};
	localparam logic [7:0] A_PCU = {IDX_PC_PUE, 2'b00};
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, can_controller_enable, can_tx;
	logic can_rx;
	logic [7:0] awaddr, araddr, keyboard_inputs, keyboard_polarity_control;
	logic [7:0] converter_input_channels, ext_b, pb_lvl;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [6:0] ext_c, ext_c_en, pc_lvl;
	gpio_pull8_t pa_pull;
	gpio_pin8_t pb_pin;
	gpio_pin7_t pc_pin;
	int fails = 0;
	int samples_checked = 0;
	int cyc = 0;

	gpio_ports i_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .rvalid, .rready, .rdata, .rresp, .keyboard_inputs,
		.keyboard_polarity_control, .pa_pull, .pb_pin_i(pb_lvl),
		.converter_input_channels, .pb_pin, .pc_pin_i(pc_lvl),
		.can_controller_enable, .can_tx, .can_rx, .pc_pin);
	gpio_pin_model i_pins (.aclk, .pb_pin, .pc_pin, .ext_b, .ext_c,
		.ext_c_en, .pb_lvl, .pc_lvl);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	task automatic end_sim;
		if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		bready <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (bvalid !== 1'b1) @(posedge aclk);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		rready <= 1'b0;
		chk(rdata, ed);
		chk(32'(rresp), 32'(er));
	endtask : rd

	task automatic do_rst;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : do_rst

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
		{wdata, keyboard_inputs, keyboard_polarity_control} = '0;
		{converter_input_channels, can_controller_enable, can_tx} = '0;
		{ext_b, ext_c} = '0;
		ext_c_en = 7'h7f;
		wstrb = 4'hf;
		aresetn = 1'b0;
		do_rst();
		rd(A_PBR, 32'h00);
		rd(A_PCR, 32'h00);
		rd(A_PAR, 32'h00);
		chk(32'({pb_pin.oe, pc_pin.oe}), 32'h0);
		ext_b <= 8'h3c;
		wr(A_PBD, 32'ha5);
		rd(A_PBD, 32'h3c);
		wr(A_PBR, 32'h0f);
		rd(A_PBD, 32'h35);
		chk(32'(pb_pin.oe), 32'h0f);
		chk(32'(pb_pin.o & pb_pin.oe), 32'h05);
		converter_input_channels <= 8'h01;
		repeat (3) @(posedge aclk);
		chk(32'(pb_pin.oe), 32'h0e);
		converter_input_channels <= 8'h00;
		ext_c <= 7'h55;
		wr(A_PCD, 32'hff);
		wr(A_PCR, 32'hff);
		rd(A_PCR, 32'h7f);
		wr(A_PCR, 32'h0f);
		repeat (3) @(posedge aclk);
		chk(32'(pc_pin.o & pc_pin.oe), 32'h0f);
		rd(A_PCD, 32'h5f);
		wr(A_PCU, 32'hff);
		rd(A_PCU, 32'h7f);
		chk(32'(pc_pin.pu), 32'h70);
		can_controller_enable <= 1'b1;
		repeat (5) @(posedge aclk);
		chk(32'({pc_pin.oe[1:0], pc_pin.o[0], can_rx}), 32'h4);
		can_tx <= 1'b1;
		ext_c <= 7'h57;
		repeat (5) @(posedge aclk);
		chk(32'({pc_pin.oe[1:0], pc_pin.o[0], can_rx}), 32'h7);
		can_controller_enable <= 1'b0;
		repeat (5) @(posedge aclk);
		chk(32'(pc_pin.oe[1:0]), 32'h3);
		wr(A_PAU, 32'hff);
		wr(A_PAR, 32'h0f);
		repeat (2) @(posedge aclk);
		chk(32'(pa_pull), 32'hf000);
		keyboard_inputs <= 8'h30;
		keyboard_polarity_control <= 8'h10;
		repeat (3) @(posedge aclk);
		chk(32'(pa_pull), 32'he010);
		wr(A_PAU, 32'h00);
		repeat (2) @(posedge aclk);
		chk(32'(pa_pull), 32'h2010);
		wr(8'h3c, 32'hff, RESP_SLVERR);
		rd(8'h3c, 32'h0, RESP_SLVERR);
		do_rst();
		rd(A_PAR, 32'h00);
		wr(A_PBR, 32'hff);
		rd(A_PBD, 32'ha5);
		wstrb <= 4'h0;
		wr(A_PBR, 32'h00);
		wstrb <= 4'hf;
		rd(A_PBR, 32'hff);
		wr(A_PCR, 32'h7f);
		rd(A_PCD, 32'h7f);
		end_sim();
	end
endmodule : gpio_ports_a_b_c_tb_top
